// *** rtl/port_status_pkg.sv ***
// constants and types of the port change and interrupt status block
// assumes an ahb-lite host with 32-bit data, one word per register
package port_status_pkg;
    // register indices; byte address is index times four
    localparam logic [5:0] IDX_AUX = 6'h04;
    localparam logic [5:0] IDX_ISR = 6'h05;
    localparam logic [5:0] IDX_ICLR = 6'h06;
    localparam logic [5:0] IDX_OSET = 6'h0e;
    localparam logic [5:0] IDX_OCLR = 6'h0f;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;
    // aux control fields
    localparam int AUX_BAUD = 7;
    localparam int AUX_MODE_MSB = 6;
    localparam int AUX_MODE_LSB = 4;
    localparam int AUX_TIMER = 6;
    localparam int AUX_EN_MSB = 3;
    // interrupt status bit positions
    localparam int ISR_TXA = 0;
    localparam int ISR_RXA = 1;
    localparam int ISR_BRKA = 2;
    localparam int ISR_CTR = 3;
    localparam int ISR_TXB = 4;
    localparam int ISR_RXB = 5;
    localparam int ISR_BRKB = 6;
    localparam int ISR_CHG = 7;
    // change flags sit above the live levels
    localparam int CHG_LSB = 4;
    // reset values
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] ISR_RST = 8'h00;
    localparam logic [7:0] IMR_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // counter/timer mode field codes
    localparam logic [2:0] MODE_CTR_IN2 = 3'h0;
    localparam logic [2:0] MODE_CTR_CHAN_A = 3'h1;
    localparam logic [2:0] MODE_CTR_CHAN_B = 3'h2;
    localparam logic [2:0] MODE_CTR_XTAL16 = 3'h3;
    localparam logic [2:0] MODE_TMR_IN2 = 3'h4;
    localparam logic [2:0] MODE_TMR_IN2_16 = 3'h5;
    localparam logic [2:0] MODE_TMR_XTAL = 3'h6;
    localparam logic HRESP_OKAY = 1'h0;
    // counter/timer clock sources
    typedef enum logic [2:0] {
        SRC_IN2 = 3'h0,
        SRC_IN2_DIV16 = 3'h1,
        SRC_CHAN_A = 3'h2,
        SRC_CHAN_B = 3'h3,
        SRC_XTAL = 3'h4,
        SRC_XTAL_DIV16 = 3'h5
    } ct_src_t;
endpackage

// *** rtl/port_change_status.sv ***
// output port image, aux control, input change flags and interrupt status
// assumes a single ahb-lite master; in_pins are asynchronous to hclk,
// channel event and level inputs are synchronous to hclk
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - output pins drive the inverted image bits
// - image changes only via set/clear writes
// - set register forces written ones high
// - clear register forces written ones low
// - aux bit 7 picks baud-rate set
// - modes 000-011 counter with four sources
// - modes 100-111 timer with four sources
// - timer mode yields square wave output
// - aux bits 3-0 gate changes into status 7
// - status 7 interrupts only when mask 7 set
// - change flags 7-4 set on pin changes
// - reading change register clears change flags
// - reading change register clears status bit 7
// - change register bits 3-0 show live pins
// - irq low when status and mask bits match
// - status reads ignore the mask
// - reset clears the interrupt status
// - status 7 set on enabled pin change
module port_change_status (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // general purpose pins
    input wire logic [3:0] in_pins,
    output logic [7:0] out_pins,
    // channel and counter interrupt sources
    input wire logic tx_a_int,
    input wire logic rx_a_int,
    input wire logic tx_b_int,
    input wire logic rx_b_int,
    input wire logic brk_a_evt,
    input wire logic brk_b_evt,
    input wire logic ctr_ready_evt,
    // counter/timer and baud-rate controls
    output logic baud_set_sel,
    output logic ct_timer_mode,
    output port_status_pkg::ct_src_t ct_clk_src,
    output logic ct_square_wave_en,
    // interrupt
    output logic irq_out_n
);
    import port_status_pkg::*;

    logic [7:0] aux_control_r;
    logic [7:0] output_port_image_r;
    logic [7:0] interrupt_status_r;
    logic [7:0] interrupt_status_nxt;
    logic [7:0] interrupt_mask_r;
    logic [3:0] chg_flag_r;
    logic [3:0] pin_sync_r;
    logic [3:0] cos_pulse;
    logic [7:0] irq_pending;
    logic [2:0] aux_mode;
    logic [3:0] aux_pin_en;
    logic [7:0] rd_byte;
    logic [31:0] hrdata_r;
    logic irq_n_r;
    logic baud_r;
    logic timer_r;
    ct_src_t src_r;
    ct_src_t src_nxt;

    // address phase
    logic addr_ok;
    logic rd_take;
    logic wr_take;
    logic rd_stall;
    logic [5:0] addr_idx;
    logic [5:0] wr_idx_r;
    logic wr_pend_r;
    logic [7:0] wbyte;
    logic chg_read;

    // write strobes, valid in the data phase of a write
    logic wr_aux;
    logic wr_mask;
    logic wr_iclr;

    assign addr_idx = haddr[IDX_MSB:IDX_LSB];
    assign addr_ok = hsel && (htrans == HTRANS_NONSEQ);
    // a read right behind a write waits one cycle so it sees the write
    assign rd_stall = addr_ok && !hwrite && wr_pend_r;
    assign rd_take = addr_ok && !hwrite && hready && !wr_pend_r;
    assign wr_take = addr_ok && hwrite && hready;
    assign wbyte = hwdata[7:0];
    assign chg_read = rd_take && (addr_idx == IDX_AUX);
    assign wr_aux = wr_pend_r && (wr_idx_r == IDX_AUX);
    assign wr_mask = wr_pend_r && (wr_idx_r == IDX_ISR);
    assign wr_iclr = wr_pend_r && (wr_idx_r == IDX_ICLR);

    assign hreadyout = !rd_stall;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_r;

    // write address held into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 6'h00;
        end else begin
            wr_pend_r <= wr_take;
            if (wr_take) begin
                wr_idx_r <= addr_idx;
            end
        end
    end

    // per-pin synchroniser, edge detector and sticky change flag
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            pin_watch i_watch (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin(in_pins[g]),
                .level(pin_sync_r[g]),
                .change(cos_pulse[g])
            );
            // a new change beats the clearing read
            event_flag i_flag (
                .hclk(hclk),
                .hresetn(hresetn),
                .raise(cos_pulse[g]),
                .lower(chg_read),
                .flag(chg_flag_r[g])
            );
        end
    endgenerate

    // aux control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_control_r <= AUX_RST;
        end else if (wr_aux) begin
            aux_control_r <= wbyte;
        end
    end

    assign aux_mode = aux_control_r[AUX_MODE_MSB:AUX_MODE_LSB];
    assign aux_pin_en = aux_control_r[AUX_EN_MSB:0];

    // output image, set and clear writes only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_port_image_r <= OUT_RST;
        end else if (wr_pend_r) begin
            case (wr_idx_r)
                IDX_OSET: begin
                    output_port_image_r <= output_port_image_r | wbyte;
                end
                IDX_OCLR: begin
                    output_port_image_r <= output_port_image_r & ~wbyte;
                end
                default: begin
                    output_port_image_r <= output_port_image_r;
                end
            endcase
        end
    end

    assign out_pins = ~output_port_image_r;

    // interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_mask_r <= IMR_RST;
        end else if (wr_mask) begin
            interrupt_mask_r <= wbyte;
        end
    end

    // interrupt status: sticky bits clear by write-one, sets win
    always_comb begin
        logic [7:0] clr;
        clr = 8'h00;
        if (wr_iclr) begin
            clr = wbyte;
        end
        interrupt_status_nxt = interrupt_status_r & ~clr;
        if (chg_read) begin
            interrupt_status_nxt[ISR_CHG] = 1'b0;
        end
        if (|(cos_pulse & aux_pin_en)) begin
            interrupt_status_nxt[ISR_CHG] = 1'b1;
        end
        if (brk_a_evt) begin
            interrupt_status_nxt[ISR_BRKA] = 1'b1;
        end
        if (brk_b_evt) begin
            interrupt_status_nxt[ISR_BRKB] = 1'b1;
        end
        if (ctr_ready_evt) begin
            interrupt_status_nxt[ISR_CTR] = 1'b1;
        end
        // level sources follow their inputs
        interrupt_status_nxt[ISR_TXA] = tx_a_int;
        interrupt_status_nxt[ISR_RXA] = rx_a_int;
        interrupt_status_nxt[ISR_TXB] = tx_b_int;
        interrupt_status_nxt[ISR_RXB] = rx_b_int;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_status_r <= ISR_RST;
        end else begin
            interrupt_status_r <= interrupt_status_nxt;
        end
    end

    // interrupt line, one cycle behind the status
    assign irq_pending = interrupt_status_r & interrupt_mask_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~|irq_pending;
        end
    end

    assign irq_out_n = irq_n_r;

    // counter/timer mode decode
    always_comb begin
        case (aux_mode)
            MODE_CTR_IN2: src_nxt = SRC_IN2;
            MODE_CTR_CHAN_A: src_nxt = SRC_CHAN_A;
            MODE_CTR_CHAN_B: src_nxt = SRC_CHAN_B;
            MODE_CTR_XTAL16: src_nxt = SRC_XTAL_DIV16;
            MODE_TMR_IN2: src_nxt = SRC_IN2;
            MODE_TMR_IN2_16: src_nxt = SRC_IN2_DIV16;
            MODE_TMR_XTAL: src_nxt = SRC_XTAL;
            default: src_nxt = SRC_XTAL_DIV16;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_r <= 1'b0;
            timer_r <= 1'b0;
            src_r <= SRC_IN2;
        end else begin
            baud_r <= aux_control_r[AUX_BAUD];
            timer_r <= aux_control_r[AUX_TIMER];
            src_r <= src_nxt;
        end
    end

    assign baud_set_sel = baud_r;
    assign ct_timer_mode = timer_r;
    assign ct_clk_src = src_r;
    assign ct_square_wave_en = timer_r;

    // read byte selected in the address phase
    always_comb begin
        rd_byte = 8'h00;
        case (addr_idx)
            IDX_AUX: begin
                rd_byte = {chg_flag_r, pin_sync_r};
            end
            IDX_ISR: begin
                rd_byte = interrupt_status_r;
            end
            IDX_OSET, IDX_OCLR: begin
                rd_byte = output_port_image_r;
            end
            IDX_ICLR: begin
                rd_byte = interrupt_mask_r;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // captured at the address phase edge, stands until the next read is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= RD_ZERO;
        end else if (rd_take) begin
            hrdata_r <= {RD_ZERO[31:8], rd_byte};
        end
    end

    logic unused;
    assign unused = ^{haddr[31:8], haddr[1:0], hsize, hwdata[31:8]};
endmodule

// two-flop synchroniser with a one-cycle change pulse for one input pin
module pin_watch (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous pin
    input wire logic pin,
    // synchronised level and change pulse
    output logic level,
    output logic change
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // only sync_r reads meta_r, so nothing sees a metastable value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign change = sync_r ^ prev_r;
endmodule

// sticky flag: a raise in the same cycle as a lower wins
module event_flag (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // controls
    input wire logic raise,
    input wire logic lower,
    // state
    output logic flag
);
    logic flag_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 1'b0;
        end else if (raise) begin
            flag_r <= 1'b1;
        end else if (lower) begin
            flag_r <= 1'b0;
        end
    end

    assign flag = flag_r;
endmodule

`default_nettype wire

// *** tb/port_change_status_props.sv ***
// assertions on the port block's bus, pins and control outputs
// assumes one ahb-lite master with hready tied to hreadyout
`timescale 1ns/1ns
`default_nettype none
module port_change_status_props (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // pins and controls
    input wire logic [7:0] out_pins,
    input wire logic baud_set_sel,
    input wire logic ct_timer_mode,
    input wire logic ct_square_wave_en,
    input wire logic irq_out_n
);
    logic wset_r, wclr_r, waux_r, take;
    assign take = hsel && htrans == 2'h2 && hready && hwrite;
    // which register the write now in its data phase is aimed at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wset_r <= 1'b0;
            wclr_r <= 1'b0;
            waux_r <= 1'b0;
        end else if (hready) begin
            wset_r <= take && haddr[7:2] == 6'h0e;
            wclr_r <= take && haddr[7:2] == 6'h0f;
            waux_r <= take && haddr[7:2] == 6'h04;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_set_drives_low: assert property (wset_r |=> (out_pins & $past(hwdata[7:0])) == 8'h00)
        else $error("set write left a pin high");
    a_clear_drives_high: assert property (wclr_r |=> (~out_pins & $past(hwdata[7:0])) == 8'h00)
        else $error("clear write left a pin low");
    a_image_holds: assert property (!(wset_r || wclr_r) |=> $stable(out_pins))
        else $error("pins moved without a set or clear write");
    a_aux_fields: assert property (waux_r && hready |=> ##1 baud_set_sel == $past(hwdata[7], 2) && ct_timer_mode == $past(hwdata[6], 2))
        else $error("aux fields not applied");
    a_square_wave: assert property (ct_square_wave_en == ct_timer_mode)
        else $error("square wave enable differs from timer mode");
    a_reset_idle: assert property ($rose(hresetn) |-> irq_out_n && out_pins == 8'hff)
        else $error("outputs not idle after reset");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
endmodule
bind port_change_status port_change_status_props i_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hresp(hresp), .hrdata(hrdata), .out_pins(out_pins),
    .baud_set_sel(baud_set_sel), .ct_timer_mode(ct_timer_mode),
    .ct_square_wave_en(ct_square_wave_en), .irq_out_n(irq_out_n));
`default_nettype wire

// *** tb/host_bus_master.sv ***
// ahb-lite host model: single word transfers, one at a time
// assumes hready is the slave's hreadyout
`timescale 1ns/1ns
`default_nettype none
module host_bus_master (
    // clock
    input wire logic hclk,
    // bus
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // released lines must not keep their last value
        hwdata <= ~d;
        haddr <= ~haddr;
        @(negedge hclk);
    endtask
endmodule
`default_nettype wire

// *** tb/test_port_change_status.sv ***
// self-checking bench for the port change and interrupt status block
// assumes host_bus_master and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module test_port_change_status;
    import port_status_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hresp, baud, timer, sq, irq_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] in_pins = 4'h0;
    logic [7:0] out_pins;
    logic [6:0] src = 7'h00;
    ct_src_t ct_src;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    always #50 hclk = ~hclk;
    host_bus_master i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    port_change_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .in_pins(in_pins),
        .out_pins(out_pins), .tx_a_int(src[0]), .rx_a_int(src[1]), .brk_a_evt(src[2]),
        .ctr_ready_evt(src[3]), .tx_b_int(src[4]), .rx_b_int(src[5]), .brk_b_evt(src[6]),
        .baud_set_sel(baud), .ct_timer_mode(timer), .ct_clk_src(ct_src),
        .ct_square_wave_en(sq), .irq_out_n(irq_n));
    task automatic summarize();
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, {24'h00_0000, d}, q);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0000_0000, q);
        check($sformatf("register %h", a), q, e);
    endtask
    // pins need three edges to reach the flags
    task automatic pins(input logic [3:0] v);
        @(posedge hclk);
        in_pins <= v;
        repeat (5) @(posedge hclk);
    endtask
    task automatic test_outputs();
        check("out_pins", out_pins, 8'hff);
        check("irq_out_n", irq_n, 1'b1);
        chk(8'h14, 32'h0000_0000);
        wr(8'h38, 8'ha5);
        check("out_pins", out_pins, 8'h5a);
        wr(8'h3c, 8'h0f);
        check("out_pins", out_pins, 8'h5f);
        wr(8'h40, 8'hff);
        check("out_pins", out_pins, 8'h5f);
        chk(8'h40, 32'h0000_0000);
        chk(8'h38, 32'h0000_00a0);
    endtask
    task automatic test_aux();
        ct_src_t exp_src [8] = '{SRC_IN2, SRC_CHAN_A, SRC_CHAN_B, SRC_XTAL_DIV16, SRC_IN2,
                                 SRC_IN2_DIV16, SRC_XTAL, SRC_XTAL_DIV16};
        for (int m = 0; m < 8; m++) begin
            wr(8'h10, {m[0], m[2:0], 4'h0});
            @(posedge hclk);
            @(negedge hclk);
            check("baud_set_sel", baud, m[0]);
            check("ct_timer_mode", timer, m[2]);
            check("ct_clk_src", ct_src, exp_src[m]);
            check("ct_square_wave_en", sq, m[2]);
        end
    endtask
    task automatic test_change();
        wr(8'h10, 8'h01);
        wr(8'h14, 8'h80);
        pins(4'h2);
        chk(8'h14, 32'h0000_0000);
        pins(4'h3);
        chk(8'h14, 32'h0000_0080);
        check("irq_out_n", irq_n, 1'b0);
        chk(8'h10, 32'h0000_0033);
        chk(8'h14, 32'h0000_0000);
        check("irq_out_n", irq_n, 1'b1);
        chk(8'h10, 32'h0000_0003);
        wr(8'h14, 8'h00);
        pins(4'h0);
        chk(8'h14, 32'h0000_0080);
        check("irq_out_n", irq_n, 1'b1);
        chk(8'h10, 32'h0000_0030);
        wr(8'h10, 8'h00);
    endtask
    task automatic test_events();
        for (int i = 0; i < 7; i++) begin
            @(posedge hclk);
            src <= 7'(1 << i);
            wr(8'h14, 8'(1 << i));
            chk(8'h14, 32'(1 << i));
            check("irq_out_n", irq_n, 1'b0);
            @(posedge hclk);
            src <= 7'h00;
            wr(8'h18, 8'(1 << i));
            chk(8'h14, 32'h0000_0000);
            check("irq_out_n", irq_n, 1'b1);
        end
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        test_outputs();
        test_aux();
        test_change();
        test_events();
        summarize();
    end
endmodule
`default_nettype wire
